//--- blt_transceiver.sv
// Contract
// - Master at frame sync sends captured voice plus sampled control bits as one burst.
// - Master stores decoded return field; control bits appear at next frame sync.
// - Master loads decoded voice into transmit register, shifts out under enable.
// - Master updates valid flag on frame sync rising edge.
// - Slave on demodulation buffers field, loads reply, raises enable, updates outputs.
// - Slave reply modulation starts exactly four bit periods after demodulation.
// - Slave drives voice bits on codec clock rising edges while enable high.
// - Ninth codec rise swaps enables; eight following falling edges sample input.
// - Slave receive enable is always the inverse of transmit enable.
// - Slave codec clock is the 4.096 MHz oscillator divided by 32.
// - Slave holds sixteenth low phase until next demodulation completes.
// - Master in power-down stops sending, updates outputs on demodulation.
// - Power-down outputs hold until three quiet syncs or another burst.
// - After power-up master waits three syncs or sync after a burst.
// - First burst uses prior captured voice and control bits of current sync.
// - Slave powered down keeps receive path and outputs but sends nothing.
// - Powered slave without bursts for 250 us starts 125 us internal frames.
// - Free-running slave bursts every second frame with last word and bits.
// - Slave weakly drives power-down pin high on burst, low after timeout.
// - Zero is a carrier phase reversal, one continues in phase.
// - Reversal cusp becomes one 128 kHz half cycle.
// - Each burst opens and closes with a 256 kHz half cycle.
`timescale 1ns/1ps
module blt_transceiver
  import blt_pkg::*;
#(
  parameter int unsigned NOBURST_CYC_P = NOBURST_CYC,
  parameter int unsigned FRAME_CYC_P = FRAME_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_frame_sync_i,
  input wire logic line_card_bit_clock_i,
  input wire logic receive_word_enable_i,
  input wire logic transmit_word_enable_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  input wire logic control_bit_in_a_i,
  input wire logic control_bit_in_b_i,
  output logic control_bit_out_a_o,
  output logic control_bit_out_b_o,
  output logic valid_frame_flag_o,
  input wire logic power_down_pin_i,
  output logic power_down_pin_o,
  output logic power_down_pin_oe_o,
  output logic codec_clock_o,
  output logic transmit_word_enable_o,
  output logic receive_word_enable_o,
  input wire logic demod_done_i,
  input wire logic demod_ok_i,
  input wire blt_field_t demod_field_i,
  output blt_line_t line_o
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [1:0] ctrl_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [5:0] status_w;
  blt_field_t dbuf_ff;
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire ctrl_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  wire en = ctrl_ff[CTRL_EN_BIT];
  wire slave = ctrl_ff[CTRL_SLAVE_BIT];
  wire pd_up = power_down_pin_i;

  // Unmapped addresses still ack, reading zero
  always_comb begin
    nxt_rdat = 32'h0;
    case (wb_adr_i)
      REG_CTRL: nxt_rdat = {30'h0, ctrl_ff};
      REG_STATUS: nxt_rdat = {26'h0, status_w};
      REG_FIELD: nxt_rdat = {22'h0, dbuf_ff};
      default: nxt_rdat = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) rdat_ff <= nxt_rdat;
      if (ctrl_wr) ctrl_ff <= wb_dat_i[1:0];
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------------------------------
  // Edge detection and oscillator tick
  // ----------------------------------------------------------------
  logic msi_d_ff, bclk_d_ff, rwe_d_ff, twe_d_ff;
  logic [17:0] acc_ff;
  wire [17:0] nxt_acc = acc_ff + OSC_KHZ;
  wire osc_tick = (nxt_acc >= CLK_KHZ);
  wire msi_rise = en & ~slave & master_frame_sync_i & ~msi_d_ff;
  wire bclk_rise = line_card_bit_clock_i & ~bclk_d_ff;
  wire bclk_fall = ~line_card_bit_clock_i & bclk_d_ff;
  wire rwe_rise = receive_word_enable_i & ~rwe_d_ff;
  wire twe_rise = transmit_word_enable_i & ~twe_d_ff;
  wire demod_ev = en & demod_done_i;
  wire dm_slave = demod_ev & slave;

  // Fractional divider: 4.096 MHz is not an integer ratio of 200 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msi_d_ff <= 1'b0;
      bclk_d_ff <= 1'b0;
      rwe_d_ff <= 1'b0;
      twe_d_ff <= 1'b0;
      acc_ff <= 18'h0;
    end else begin
      msi_d_ff <= master_frame_sync_i;
      bclk_d_ff <= line_card_bit_clock_i;
      rwe_d_ff <= receive_word_enable_i;
      twe_d_ff <= transmit_word_enable_i;
      acc_ff <= osc_tick ? nxt_acc - CLK_KHZ : nxt_acc;
    end
  end

  // ----------------------------------------------------------------
  // Slave codec clock and word enables
  // ----------------------------------------------------------------
  logic crun_ff, cphase_ff, twe_ff;
  logic [3:0] cnt_ff;
  logic [4:0] cper_ff;
  wire half_end = crun_ff & osc_tick & (cnt_ff == OSC_HALF_LAST);
  wire run_rise = half_end & ~cphase_ff & (cper_ff != CODEC_PERIODS_LAST);
  wire codec_fall = half_end & cphase_ff;
  wire codec_rise = dm_slave | run_rise;
  wire ninth_rise = run_rise & ~dm_slave & ((cper_ff + 5'h1) == VOICE_BITS);

  // Demodulation restarts the clock; the last low phase absorbs slip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crun_ff <= 1'b0;
      cphase_ff <= 1'b0;
      cnt_ff <= 4'h0;
      cper_ff <= 5'h0;
      twe_ff <= 1'b0;
    end else if (dm_slave) begin
      crun_ff <= 1'b1;
      cphase_ff <= 1'b1;
      cnt_ff <= 4'h0;
      cper_ff <= 5'h0;
      twe_ff <= 1'b1;
    end else begin
      if (crun_ff && osc_tick) cnt_ff <= (cnt_ff == OSC_HALF_LAST) ? 4'h0 : cnt_ff + 4'h1;
      if (codec_fall) cphase_ff <= 1'b0;
      if (half_end && !cphase_ff) begin
        if (cper_ff == CODEC_PERIODS_LAST) begin
          crun_ff <= 1'b0;
        end else begin
          cphase_ff <= 1'b1;
          cper_ff <= cper_ff + 5'h1;
        end
      end
      if (ninth_rise) twe_ff <= 1'b0;
      if (!slave) twe_ff <= 1'b0;
    end
  end
  assign codec_clock_o = slave & cphase_ff;
  assign transmit_word_enable_o = twe_ff;
  assign receive_word_enable_o = slave & ~twe_ff;

  // ----------------------------------------------------------------
  // Voice serial paths
  // ----------------------------------------------------------------
  logic [7:0] txreg_ff, tx_sh_ff, rx_sh_ff, rxreg_ff;
  logic [3:0] rx_cnt_ff;
  logic sdo_ff;
  wire [7:0] sh_src = dm_slave ? demod_field_i.voice : (twe_rise ? txreg_ff : tx_sh_ff);
  wire mst_shift = ~slave & bclk_rise & transmit_word_enable_i;
  wire slv_shift = dm_slave | (run_rise & twe_ff & ~ninth_rise);
  wire rx_arm = slave ? ninth_rise : rwe_rise;
  wire rx_samp = (slave ? codec_fall : bclk_fall) & (rx_cnt_ff != 4'h0);

  // Shift out on rising edges, capture on falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txreg_ff <= 8'h0;
      tx_sh_ff <= 8'h0;
      rx_sh_ff <= 8'h0;
      rxreg_ff <= 8'h0;
      rx_cnt_ff <= 4'h0;
      sdo_ff <= 1'b0;
    end else begin
      if (demod_ev) txreg_ff <= demod_field_i.voice;
      if (mst_shift || slv_shift) begin
        sdo_ff <= sh_src[7];
        tx_sh_ff <= {sh_src[6:0], 1'b0};
      end else if (twe_rise) begin
        tx_sh_ff <= txreg_ff;
      end
      if (rx_arm) begin
        rx_cnt_ff <= 4'h8;
      end else if (rx_samp) begin
        rx_sh_ff <= {rx_sh_ff[6:0], serial_data_i};
        rx_cnt_ff <= rx_cnt_ff - 4'h1;
        if (rx_cnt_ff == 4'h1) rxreg_ff <= {rx_sh_ff[6:0], serial_data_i};
      end
    end
  end
  assign serial_data_o = sdo_ff;
  assign serial_data_oe_o = en & (slave ? twe_ff : transmit_word_enable_i);

  // ----------------------------------------------------------------
  // Frame state: buffers, power-down, idle timeout, free run
  // ----------------------------------------------------------------
  logic dok_ff, seen_ff, armed_ff, to_ff, alt_ff, pd_o_ff;
  logic out_a_ff, out_b_ff, valid_ff;
  logic [1:0] mq_ff, wake_ff;
  logic [15:0] idle_ff, fr_ff;
  wire mst_go = armed_ff | seen_ff | (wake_ff == MSI_QUIET_LAST);
  wire mst_start = msi_rise & pd_up & mst_go;
  wire mq_hit = msi_rise & ~seen_ff & (mq_ff == MSI_QUIET_LAST);
  wire idle_hit = slave & (idle_ff == 16'(NOBURST_CYC_P - 1));
  wire free_run = en & slave & to_ff & pd_up;
  wire frame_tick = free_run & (fr_ff == 16'(FRAME_CYC_P - 1));
  wire fr_start = frame_tick & alt_ff;
  wire reply = dm_slave & pd_up;

  // Master keeps its own quiet-sync and wake counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbuf_ff <= '0;
      dok_ff <= 1'b0;
      seen_ff <= 1'b0;
      mq_ff <= 2'h0;
      wake_ff <= 2'h0;
      armed_ff <= 1'b0;
    end else begin
      if (demod_ev) begin
        dbuf_ff <= demod_field_i;
        dok_ff <= demod_ok_i;
      end
      // A burst landing on the sync edge is kept for the next frame
      if (demod_ev && !slave) seen_ff <= 1'b1;
      else if (msi_rise || slave) seen_ff <= 1'b0;
      if (demod_ev) mq_ff <= 2'h0;
      else if (msi_rise && !seen_ff && mq_ff != 2'h3) mq_ff <= mq_ff + 2'h1;
      if (!pd_up) wake_ff <= 2'h0;
      else if (msi_rise && wake_ff != 2'h3) wake_ff <= wake_ff + 2'h1;
      armed_ff <= pd_up & (armed_ff | mst_start);
    end
  end

  // Control outputs and valid flag for both roles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else if (slave) begin
      if (dm_slave) begin
        out_a_ff <= demod_field_i.ctl_a;
        out_b_ff <= demod_field_i.ctl_b;
        valid_ff <= demod_ok_i;
      end else if (idle_hit) begin
        valid_ff <= 1'b0;
      end
    end else if (!pd_up) begin
      if (demod_ev) begin
        out_a_ff <= demod_field_i.ctl_a;
        out_b_ff <= demod_field_i.ctl_b;
        valid_ff <= demod_ok_i;
      end else if (mq_hit) begin
        valid_ff <= 1'b0;
      end
    end else if (msi_rise) begin
      out_a_ff <= dbuf_ff.ctl_a;
      out_b_ff <= dbuf_ff.ctl_b;
      valid_ff <= seen_ff & dok_ff;
    end
  end
  assign control_bit_out_a_o = out_a_ff;
  assign control_bit_out_b_o = out_b_ff;
  assign valid_frame_flag_o = valid_ff;

  // Slave idle timeout, free-running frame clock and weak pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_ff <= 16'h0;
      to_ff <= 1'b0;
      fr_ff <= 16'h0;
      alt_ff <= 1'b0;
      pd_o_ff <= 1'b0;
    end else if (dm_slave || !slave || !en) begin
      idle_ff <= 16'h0;
      to_ff <= 1'b0;
      fr_ff <= 16'h0;
      alt_ff <= 1'b0;
      if (dm_slave) pd_o_ff <= 1'b1;
    end else begin
      if (!to_ff) idle_ff <= idle_ff + 16'h1;
      if (idle_hit) begin
        to_ff <= 1'b1;
        pd_o_ff <= 1'b0;
      end
      if (free_run) begin
        fr_ff <= frame_tick ? 16'h0 : fr_ff + 16'h1;
        if (frame_tick) alt_ff <= ~alt_ff;
      end
    end
  end
  assign power_down_pin_o = pd_o_ff;
  assign power_down_pin_oe_o = en & slave;

  // ----------------------------------------------------------------
  // Modified DPSK modulator
  // ----------------------------------------------------------------
  blt_mod_state_t mstate_ff;
  blt_field_t mbuf_ff;
  logic [9:0] mbits_ff;
  logic [11:0] dly_ff;
  logic [8:0] hcnt_ff;
  logic [4:0] slot_ff;
  logic lvl_ff, drv_ff;
  wire idle_m = (mstate_ff == MS_IDLE);
  wire go_now = idle_m & (mst_start | fr_start);
  wire go_wait = (mstate_ff == MS_WAIT) & (dly_ff == 12'(SLAVE_TURN_CYC));
  wire half_done = (hcnt_ff == 9'(HALF_CYC - 1));
  wire [4:0] nxt_slot = slot_ff + 5'h1;
  // Captured voice plus control bits sampled on this trigger edge
  wire blt_field_t cap_field = '{voice: rxreg_ff, ctl_a: control_bit_in_a_i, ctl_b: control_bit_in_b_i};

  // Busy modulator ignores new triggers; one burst per frame is expected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mstate_ff <= MS_IDLE;
      mbuf_ff <= '0;
      mbits_ff <= 10'h0;
      dly_ff <= 12'h0;
      hcnt_ff <= 9'h0;
      slot_ff <= 5'h0;
      lvl_ff <= 1'b0;
      drv_ff <= 1'b0;
    end else begin
      case (mstate_ff)
        MS_IDLE: begin
          if (go_now) begin
            mbuf_ff <= cap_field;
            mbits_ff <= cap_field;
            mstate_ff <= MS_SEND;
            slot_ff <= 5'h0;
            hcnt_ff <= 9'h0;
            lvl_ff <= 1'b1;
            drv_ff <= 1'b1;
          end else if (reply) begin
            mbuf_ff <= cap_field;
            dly_ff <= 12'h1;
            mstate_ff <= MS_WAIT;
          end
        end
        MS_WAIT: begin
          dly_ff <= dly_ff + 12'h1;
          if (go_wait) begin
            mbits_ff <= mbuf_ff;
            mstate_ff <= MS_SEND;
            slot_ff <= 5'h0;
            hcnt_ff <= 9'h0;
            lvl_ff <= 1'b1;
            drv_ff <= 1'b1;
          end
        end
        MS_SEND: begin
          hcnt_ff <= half_done ? 9'h0 : hcnt_ff + 9'h1;
          if (half_done) begin
            slot_ff <= nxt_slot;
            if (slot_ff == MOD_SLOT_LAST) begin
              drv_ff <= 1'b0;
              mstate_ff <= MS_IDLE;
            end else if (nxt_slot[0] && nxt_slot != MOD_SLOT_LAST) begin
              // Zero repeats the level: reversal merges into a 128 kHz half
              lvl_ff <= mbits_ff[9] ? ~lvl_ff : lvl_ff;
              mbits_ff <= {mbits_ff[8:0], 1'b0};
            end else begin
              lvl_ff <= ~lvl_ff;
            end
          end
        end
        default: begin
          mstate_ff <= MS_IDLE;
          drv_ff <= 1'b0;
        end
      endcase
    end
  end
  assign line_o = '{pos: drv_ff & lvl_ff, neg: drv_ff & ~lvl_ff, drive: drv_ff};
  assign status_w = {armed_ff, ~idle_m, to_ff, valid_ff, out_b_ff, out_a_ff};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [12:0] since_dm_ff;
  logic [5:0] orise_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_dm_ff <= 13'h0;
      orise_ff <= 6'h0;
    end else begin
      if (dm_slave) since_dm_ff <= 13'h0;
      else if (since_dm_ff != 13'h1fff) since_dm_ff <= since_dm_ff + 13'h1;
      if (codec_rise) orise_ff <= 6'h0;
      else if (osc_tick && orise_ff != 6'h3f) orise_ff <= orise_ff + 6'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_enable_inverse: assert property (slave |-> receive_word_enable_o == ~transmit_word_enable_o)
    else $error("receive enable not inverse of transmit enable");
  a_turn_delay: assert property ($rose(drv_ff) && slave && !to_ff |-> since_dm_ff == 13'(SLAVE_TURN_CYC))
    else $error("slave reply not four bit periods after demodulation");
  a_codec_divide: assert property (run_rise && !dm_slave |-> orise_ff == 6'(OSC_DIV - 1))
    else $error("codec clock period not 32 oscillator ticks");
  a_stretch_low: assert property (slave && !crun_ff && !dm_slave |=> !codec_clock_o)
    else $error("codec clock left low stretch without demodulation");
  a_ninth_swap: assert property ($fell(twe_ff) && slave |-> $past(cper_ff) == 5'h7 && cper_ff == 5'h8)
    else $error("transmit enable did not fall on ninth rise");
  a_no_tx_pd: assert property (!slave && !pd_up && idle_m |=> !drv_ff)
    else $error("master modulated while powered down");
  a_slave_pd_quiet: assert property (slave && !pd_up && idle_m |=> !drv_ff)
    else $error("slave modulated while powered down");
  a_valid_sync: assert property (!slave && pd_up && $past(pd_up) && $changed(valid_ff) |-> $past(msi_rise))
    else $error("master valid flag changed off the sync edge");
  a_burst_lead: assert property ($rose(drv_ff) |-> lvl_ff ##1 lvl_ff [*8])
    else $error("burst did not open with a positive half cycle");
  a_pin_high: assert property (dm_slave |=> power_down_pin_o && power_down_pin_oe_o)
    else $error("power-down pin not driven high after burst");

endmodule : blt_transceiver

//--- blt_pkg.sv
package blt_pkg;

  // ----------------------------------------------------------------
  // Clock and line rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BIT_HZ = 256_000;
  localparam int unsigned BIT_CYC = CLK_HZ / BIT_HZ;
  localparam int unsigned HALF_CYC = CLK_HZ / (2 * BIT_HZ);
  localparam int unsigned SLAVE_TURN_BITS = 4;
  localparam int unsigned SLAVE_TURN_CYC = SLAVE_TURN_BITS * BIT_CYC;
  // Oscillator emulated by a phase accumulator, in kHz steps
  localparam logic [17:0] OSC_KHZ = 18'h01000;
  localparam logic [17:0] CLK_KHZ = 18'h30d40;
  localparam int unsigned OSC_DIV = 32;
  localparam logic [3:0] OSC_HALF_LAST = 4'((OSC_DIV / 2) - 1);
  localparam logic [4:0] CODEC_PERIODS_LAST = 5'h0f;
  localparam logic [4:0] VOICE_BITS = 5'h08;
  // Idle and free-run times
  localparam int unsigned NOBURST_NS = 250_000;
  localparam int unsigned FRAME_NS = 125_000;
  localparam int unsigned NOBURST_CYC = (CLK_HZ / 1_000_000) * NOBURST_NS / 1000;
  localparam int unsigned FRAME_CYC = (CLK_HZ / 1_000_000) * FRAME_NS / 1000;
  localparam logic [1:0] MSI_QUIET_LAST = 2'h2;
  // Burst layout: lead half, ten bits of two halves, trail half
  localparam logic [4:0] MOD_SLOT_LAST = 5'h15;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FIELD = 8'h08;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SLAVE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] voice;
    logic ctl_a;
    logic ctl_b;
  } blt_field_t;

  typedef struct packed {
    logic pos;
    logic neg;
    logic drive;
  } blt_line_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_WAIT = 3'b010,
    MS_SEND = 3'b100
  } blt_mod_state_t;

endpackage : blt_pkg

//--- blt_far_end.sv
`timescale 1ns/1ps
module blt_far_end
  import blt_pkg::*;
(
  input wire logic clk_i,
  input wire blt_line_t line_i,
  output logic done_o,
  output logic ok_o,
  output blt_field_t field_o
);
  // Quiet front end until the send task drives a decoded field
  initial begin
    done_o = 1'b0;
    ok_o = 1'b0;
    field_o = '0;
  end

  // One decoded field as a single-cycle pulse; field scrambled after it,
  // so a late sample of the data never sees the old value
  task automatic send(input blt_field_t f);
    @(posedge clk_i);
    done_o <= 1'b1;
    ok_o <= 1'b1;
    field_o <= f;
    @(posedge clk_i);
    done_o <= 1'b0;
    ok_o <= 1'b0;
    field_o <= ~f;
  endtask : send

  // Level at mid-half; a level repeated across a bit start marks a zero
  task automatic listen(output logic [9:0] f);
    logic prev;
    int i;
    f = '0;
    for (i = 0; i < 30000 && line_i.drive !== 1'b1; i++) @(posedge clk_i);
    repeat (HALF_CYC / 2) @(posedge clk_i);
    for (i = 0; i < 10; i++) begin
      prev = line_i.pos;
      repeat (HALF_CYC) @(posedge clk_i);
      f = {f[8:0], line_i.pos !== prev};
      repeat (HALF_CYC) @(posedge clk_i);
    end
  endtask : listen
endmodule : blt_far_end

//--- blt_transceiver_test.sv
`timescale 1ns/1ps
module blt_transceiver_test;
  import blt_pkg::*;
  localparam int FR = 5000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync = 1'b0, pin = 1'b1, rwe = 1'b0, twe = 1'b0;
  logic [7:0] adr = '0;
  logic [7:0] cnt = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat, wb_dat;
  logic ack, sdo, sdoe, oa, ob, vf, pdo, pdoe, cclk, txe, rxe, done, ok, d;
  blt_field_t fld;
  blt_line_t line;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;

  // --------------------------------------------------------------
  // Clock, serial stimulus, design and far end
  // --------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;
  // Counter feeds bit clock and serial data, so those paths move
  always @(posedge clk_i) cnt <= cnt + 8'h01;

  blt_transceiver #(.NOBURST_CYC_P(12000), .FRAME_CYC_P(FR)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .master_frame_sync_i(sync), .line_card_bit_clock_i(cnt[4]), .receive_word_enable_i(rwe),
    .transmit_word_enable_i(twe), .serial_data_i(cnt[6]), .serial_data_o(sdo),
    .serial_data_oe_o(sdoe), .control_bit_in_a_i(~sync), .control_bit_in_b_i(sync),
    .control_bit_out_a_o(oa), .control_bit_out_b_o(ob), .valid_frame_flag_o(vf),
    .power_down_pin_i(pin), .power_down_pin_o(pdo), .power_down_pin_oe_o(pdoe),
    .codec_clock_o(cclk), .transmit_word_enable_o(txe), .receive_word_enable_o(rxe),
    .demod_done_i(done), .demod_ok_i(ok), .demod_field_i(fld), .line_o(line));

  blt_far_end u_far (.clk_i(clk_i), .line_i(line), .done_o(done), .ok_o(ok), .field_o(fld));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic single cycle; hold until ack, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    rdat = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wb

  // Cycles until the line driver starts a new burst
  task automatic wait_rise(output int k);
    logic prev;
    k = 0;
    prev = line.drive;
    while (!(line.drive === 1'b1 && prev === 1'b0) && k < 30000) begin
      prev = line.drive;
      @(posedge clk_i);
      #1 k++;
    end
    if (k >= 30000) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_rise

  // One frame sync pulse; burst state sampled four cycles after its rise, while sync is still high
  task automatic frame(output logic drv);
    @(posedge clk_i);
    sync <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 drv = line.drive;
    @(posedge clk_i);
    sync <= 1'b0;
    repeat (8700) @(posedge clk_i);
  endtask : frame

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    wb(1'b0, REG_CTRL, '0);
    chk("ctrl reset", rdat, 32'h0);
    wb(1'b0, 8'h0c, '0);
    chk("unmapped read", rdat, 32'h0);
    wb(1'b1, REG_CTRL, 32'h3);
    wb(1'b0, REG_CTRL, '0);
    chk("ctrl readback", rdat, 32'h3);
  endtask : t_regs

  task automatic t_slave;
    int r;
    int k;
    logic [9:0] lf;
    u_far.send({8'ha5, 2'b10});
    #1;
    chk("tx enable", txe, 1'b1);
    chk("rx enable low", rxe, 1'b0);
    chk("ctl outs", {vf, oa, ob}, 3'b110);
    chk("pd weak high", {pdoe, pdo}, 2'b11);
    chk("first voice bit", {sdoe, sdo}, 2'b11);
    // Reply timing and codec window watched side by side
    fork
      begin
        wait_rise(n);
        chk("reply delay", n, SLAVE_TURN_CYC);
        chk("line pair", {line.pos, line.neg}, 2'b10);
        u_far.listen(lf);
        chk("reply field", lf, 10'h002);
      end
      begin
        r = 1;
        for (k = 0; k < 20000 && txe === 1'b1; k++) begin
          d = cclk;
          @(posedge clk_i);
          #1 r += int'(cclk && !d);
        end
        chk("codec rises in tx window", r, 9);
        chk("rx enable high", rxe, 1'b1);
      end
    join
    wb(1'b0, REG_FIELD, '0);
    chk("decoded field", rdat, 32'h296);
  endtask : t_slave

  task automatic t_free;
    wait_rise(n);
    chk("pd weak low", {pdoe, pdo}, 2'b10);
    wait_rise(n);
    chk("free run spacing", n, 2 * FR);
    wb(1'b0, REG_STATUS, '0);
    chk("free run status", rdat[3], 1'b1);
    repeat (8600) @(posedge clk_i);
  endtask : t_free

  task automatic t_master;
    logic [1:0] held;
    logic [9:0] lf;
    logic [7:0] v;
    int k;
    wb(1'b1, REG_CTRL, 32'h1);
    // Receive window aligned to the counter: falls sample 0,1,1,0,0,1,1,0
    for (k = 0; k < 300 && cnt !== 8'h00; k++) @(posedge clk_i);
    if (k == 300) n_mismatch++;
    rwe <= 1'b1;
    repeat (300) @(posedge clk_i);
    rwe <= 1'b0;
    frame(d);
    chk("no burst sync 1", d, 1'b0);
    frame(d);
    chk("no burst sync 2", d, 1'b0);
    fork
      frame(d);
      u_far.listen(lf);
    join
    chk("first burst field", lf, 10'h199);
    frame(d);
    chk("burst at sync", d, 1'b1);
    held = {oa, ob};
    u_far.send({8'h3c, 2'b01});
    #1 chk("outs wait for sync", {oa, ob}, held);
    // Decoded voice goes out one bit per bit clock rise
    @(posedge clk_i);
    twe <= 1'b1;
    v = '0;
    n = 0;
    for (k = 0; k < 400 && n < 8; k++) begin
      @(posedge clk_i);
      #1;
      if (cnt[4:0] == 5'h11) begin
        v = {v[6:0], sdo};
        n++;
      end
    end
    chk("serial enable", sdoe, 1'b1);
    chk("master voice out", v, 8'h3c);
    @(posedge clk_i);
    twe <= 1'b0;
    frame(d);
    chk("outs at sync", {oa, ob}, 2'b01);
    chk("valid at sync", vf, 1'b1);
    chk("burst after demod", d, 1'b1);
    // Power-down: outputs follow demodulation, line stays quiet
    @(posedge clk_i);
    pin <= 1'b0;
    u_far.send({8'h11, 2'b10});
    #1 chk("pd outs on demod", {oa, ob}, 2'b10);
    frame(d);
    chk("pd no burst", d, 1'b0);
  endtask : t_master

  // Powered-down slave still answers locally but never replies
  task automatic t_slave_pd;
    wb(1'b1, REG_CTRL, 32'h3);
    u_far.send({8'h5a, 2'b01});
    #1 chk("pd slave outs", {txe, oa, ob, pdo}, 4'b1011);
    repeat (SLAVE_TURN_CYC + 100) @(posedge clk_i);
    chk("pd slave no reply", line.drive, 1'b0);
  endtask : t_slave_pd

  // Reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_slave();
    t_free();
    t_master();
    t_slave_pd();
    complete_run();
  end
endmodule : blt_transceiver_test
